// >>> hdl/pvpd_access.sv
// Product-data capability and data register of the primary PCI port, moving words to and from a serial EEPROM.
// Assumes synchronous config-register strobes and a byte-wide EEPROM engine with req/done handshake.
`timescale 1ns/1ps
module pvpd_access
    import pvpd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic priWrEn,
    input wire logic priRdEn,
    input wire logic [7:0] priAddr,
    input wire logic [31:0] priWrData,
    output logic [31:0] priRdData,
    input wire logic secRdEn,
    input wire logic [7:0] secAddr,
    output logic [31:0] secRdData,
    input wire logic productInfoEnable,
    input wire logic eepromDetected,
    input wire logic sharedEeprom,
    output logic [7:0] hotSwapNextPtr,
    output logic eeReq,
    output logic eeWrite,
    output logic [7:0] eeAddr,
    output logic [7:0] eeWrData,
    input wire logic eeDone,
    input wire logic [7:0] eeRdData
);
    // ------------------------------------------------------------
    // Decode and enables
    // ------------------------------------------------------------
    function automatic logic hitReg(input logic en, input logic [7:0] a, input logic [7:0] ofs);
        return en && (a == ofs);
    endfunction

    pvpd_state_e state_ff, nxt_state;
    logic flag_ff, nxt_flag;
    logic [7:0] ofs_ff, nxt_ofs;
    logic [31:0] word_ff, nxt_word;
    logic [1:0] byteIdx_ff, nxt_byteIdx;
    logic accessOn;
    logic capWr;
    logic dataWr;
    logic [7:0] xlatBase;
    logic wrAllowed;
    logic [8:0] lastOfs;

    assign hotSwapNextPtr = (productInfoEnable && eepromDetected) ? PVPD_HS_NEXT_PTR : 8'h00;
    assign accessOn = productInfoEnable && (hotSwapNextPtr != 8'h00);
    assign capWr = hitReg(priWrEn, priAddr, PVPD_CAP_OFFSET) && accessOn;
    assign dataWr = hitReg(priWrEn, priAddr, PVPD_DATA_OFFSET) && accessOn;
    assign xlatBase = sharedEeprom ? 8'(ofs_ff + PVPD_SHARED_BASE) : ofs_ff;
    // Last byte of the word, one bit wider so a wrap past the top shows up
    assign lastOfs = {1'b0, ofs_ff} + {7'h00, PVPD_LAST_BYTE};
    // Whole word must sit in the writable area; a wrap would reach read-only bytes
    assign wrAllowed = (ofs_ff >= PVPD_RO_LIMIT) && !lastOfs[8]
        && !(sharedEeprom && lastOfs[7:0] >= PVPD_SHARED_TOP);

    // A refused write never reaches the EEPROM engine
    assign eeReq = (state_ff == PV_RD_REQ) || (state_ff == PV_WR_REQ && wrAllowed);
    assign eeWrite = (state_ff == PV_WR_REQ);
    assign eeAddr = 8'(xlatBase + {6'h00, byteIdx_ff});
    assign eeWrData = word_ff[byteIdx_ff*8 +: 8];
    assign secRdData = (secRdEn && secAddr == 8'h00) ? 32'h0000_0000 : 32'h0000_0000;

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    function automatic logic [31:0] rdMux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == PVPD_CAP_OFFSET) begin
            v = {flag_ff, 7'h00, ofs_ff, PVPD_NEXT_PTR, PVPD_CAPABILITY_IDENTIFIER};
        end else if (a == PVPD_DATA_OFFSET && accessOn) begin
            v = word_ff;
        end
        return v;
    endfunction

    // Read data is driven only while the read strobe is up
    always_comb begin
        priRdData = priRdEn ? rdMux(priAddr) : 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_flag = flag_ff;
        nxt_ofs = ofs_ff;
        nxt_word = word_ff;
        nxt_byteIdx = byteIdx_ff;
        if (dataWr && state_ff == PV_IDLE) begin
            nxt_word = priWrData;
        end
        case (state_ff)
            PV_IDLE: begin
                if (capWr) begin
                    nxt_ofs = priWrData[PVPD_OFS_LSB +: 8];
                    nxt_flag = priWrData[PVPD_FLAG_BIT];
                    nxt_byteIdx = PVPD_FIRST_BYTE;
                    nxt_state = priWrData[PVPD_FLAG_BIT] ? PV_WR_REQ : PV_RD_REQ;
                end
            end
            PV_RD_REQ: nxt_state = PV_RD_WAIT;
            PV_RD_WAIT: begin
                if (eeDone) begin
                    nxt_word[byteIdx_ff*8 +: 8] = eeRdData;
                    nxt_byteIdx = 2'(byteIdx_ff + 2'h1);
                    if (byteIdx_ff == PVPD_LAST_BYTE) begin
                        nxt_flag = 1'b1;
                        nxt_state = PV_IDLE;
                    end else begin
                        nxt_state = PV_RD_REQ;
                    end
                end
            end
            PV_WR_REQ: begin
                if (!wrAllowed) begin
                    nxt_flag = 1'b0;
                    nxt_state = PV_IDLE;
                end else begin
                    nxt_state = PV_WR_WAIT;
                end
            end
            PV_WR_WAIT: begin
                if (eeDone) begin
                    nxt_byteIdx = 2'(byteIdx_ff + 2'h1);
                    if (byteIdx_ff == PVPD_LAST_BYTE) begin
                        nxt_flag = 1'b0;
                        nxt_state = PV_IDLE;
                    end else begin
                        nxt_state = PV_WR_REQ;
                    end
                end
            end
            default: nxt_state = PV_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= PV_IDLE;
            flag_ff <= 1'b0;
            ofs_ff <= PVPD_OFS_RESET;
            word_ff <= PVPD_WORD_RESET;
            byteIdx_ff <= PVPD_FIRST_BYTE;
        end else begin
            state_ff <= nxt_state;
            flag_ff <= nxt_flag;
            ofs_ff <= nxt_ofs;
            word_ff <= nxt_word;
            byteIdx_ff <= nxt_byteIdx;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sec_reads_zero_a: assert property (secRdData == 32'h0)
        else $error("secondary read nonzero");
    disabled_no_start_a: assert property (
        !accessOn && state_ff == PV_IDLE |=> state_ff == PV_IDLE)
        else $error("transfer started while disabled");
    read_start_a: assert property (
        capWr && state_ff == PV_IDLE && !priWrData[PVPD_FLAG_BIT]
        |=> !flag_ff && state_ff == PV_RD_REQ)
        else $error("read not started");
    read_done_a: assert property (
        state_ff == PV_RD_WAIT && eeDone && byteIdx_ff == PVPD_LAST_BYTE
        |=> flag_ff && state_ff == PV_IDLE)
        else $error("read flag not set");
    idle_no_req_a: assert property (state_ff == PV_IDLE |-> !eeReq)
        else $error("request while idle");
    write_done_a: assert property (
        state_ff == PV_WR_WAIT && eeDone && byteIdx_ff == PVPD_LAST_BYTE
        |=> !flag_ff)
        else $error("write flag not cleared");
    offset_load_a: assert property (
        capWr && state_ff == PV_IDLE |=> ofs_ff == $past(priWrData[PVPD_OFS_LSB +: 8]))
        else $error("offset not loaded");
    busy_offset_a: assert property (
        capWr && state_ff != PV_IDLE |=> ofs_ff == $past(ofs_ff))
        else $error("offset changed while busy");
    shared_xlat_a: assert property (
        eeReq && sharedEeprom |-> eeAddr == 8'(ofs_ff + PVPD_SHARED_BASE + byteIdx_ff))
        else $error("bad translation");
    shared_top_a: assert property (
        eeReq && eeWrite && sharedEeprom |-> lastOfs[7:0] < PVPD_SHARED_TOP)
        else $error("write past shared area");
    ro_protect_a: assert property (eeReq && eeWrite |-> ofs_ff >= PVPD_RO_LIMIT)
        else $error("write to read-only area");
    wr_no_wrap_a: assert property (eeReq && eeWrite |-> !lastOfs[8])
        else $error("write wraps past top");
    cap_header_a: assert property (
        priRdEn && priAddr == PVPD_CAP_OFFSET |-> priRdData[15:0] == 16'h0003)
        else $error("bad capability header");
    data_zero_a: assert property (
        !productInfoEnable && priAddr == PVPD_DATA_OFFSET |-> priRdData == 32'h0)
        else $error("data visible while disabled");
    data_hold_a: assert property (
        !accessOn && state_ff == PV_IDLE |=> word_ff == $past(word_ff))
        else $error("data changed while disabled");
    word_load_a: assert property (
        dataWr && state_ff == PV_IDLE |=> word_ff == $past(priWrData))
        else $error("data word not loaded");
    hs_ptr_a: assert property (
        hotSwapNextPtr == ((productInfoEnable && eepromDetected) ? 8'hE8 : 8'h00))
        else $error("hot-swap pointer wrong");
    req_pulse_a: assert property (eeReq |=> !eeReq)
        else $error("request longer than one cycle");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    rd_cov_c: cover property (state_ff == PV_RD_WAIT && eeDone && byteIdx_ff == PVPD_LAST_BYTE);
    wr_cov_c: cover property (state_ff == PV_WR_WAIT && eeDone && byteIdx_ff == PVPD_LAST_BYTE);
    ro_cov_c: cover property (state_ff == PV_WR_REQ && !wrAllowed);
    disabled_cov_c: cover property (hitReg(priWrEn, priAddr, PVPD_CAP_OFFSET) && !accessOn);
    shared_cov_c: cover property (eeReq && sharedEeprom && !eeWrite);
endmodule

// >>> hdl/pvpd_pkg.sv
// Package: offsets, field positions and reset values of the product-data capability.
// Assumes a 32-bit configuration register port on each PCI interface.
package pvpd_pkg;
    localparam logic [7:0] PVPD_CAP_OFFSET = 8'hE8;
    localparam logic [7:0] PVPD_DATA_OFFSET = 8'hEC;
    localparam logic [7:0] PVPD_CAPABILITY_IDENTIFIER = 8'h03;
    localparam logic [7:0] PVPD_NEXT_PTR = 8'h00;
    localparam logic [7:0] PVPD_HS_NEXT_PTR = 8'hE8;
    localparam int PVPD_FLAG_BIT = 31;
    localparam int PVPD_OFS_LSB = 16;
    localparam logic [7:0] PVPD_OFS_RESET = 8'h00;
    localparam logic [31:0] PVPD_WORD_RESET = 32'h0000_0000;
    localparam logic [7:0] PVPD_SHARED_BASE = 8'h40;
    localparam logic [7:0] PVPD_RO_LIMIT = 8'h40;
    localparam logic [7:0] PVPD_SHARED_TOP = 8'hC0;
    localparam logic [1:0] PVPD_LAST_BYTE = 2'h3;
    localparam logic [1:0] PVPD_FIRST_BYTE = 2'h0;
    typedef enum logic [2:0] {PV_IDLE, PV_RD_REQ, PV_RD_WAIT, PV_WR_REQ, PV_WR_WAIT} pvpd_state_e;
endpackage

// >>> tb/pvpd_access_bench.sv
// Bench for the product-data capability: config accesses against an EEPROM model.
// Assumes the package constants and the model in pvpd_ee_model.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module pvpd_access_bench;
    import pvpd_pkg::*;
    logic mclk = 0, rst_n = 0, priWrEn = 0, priRdEn = 0, secRdEn = 0, slow = 0;
    logic productInfoEnable = 0, eepromDetected = 0, sharedEeprom = 0, eeDone, eeReq, eeWrite;
    logic [7:0] priAddr = 0, secAddr = 0, hotSwapNextPtr, eeAddr, eeWrData, eeRdData;
    logic [31:0] priWrData = 0, priRdData, secRdData, v;
    int n_errors = 0, checks_done = 0, nReq = 0, cyc = 0, n0;
    pvpd_access dut (.mclk(mclk), .rst_n(rst_n), .priWrEn(priWrEn), .priRdEn(priRdEn),
        .priAddr(priAddr), .priWrData(priWrData), .priRdData(priRdData), .secRdEn(secRdEn),
        .secAddr(secAddr), .secRdData(secRdData), .productInfoEnable(productInfoEnable),
        .eepromDetected(eepromDetected), .sharedEeprom(sharedEeprom),
        .hotSwapNextPtr(hotSwapNextPtr), .eeReq(eeReq), .eeWrite(eeWrite), .eeAddr(eeAddr),
        .eeWrData(eeWrData), .eeDone(eeDone), .eeRdData(eeRdData));
    pvpd_ee_model ee (.mclk(mclk), .slow(slow), .eeReq(eeReq), .eeWrite(eeWrite),
        .eeAddr(eeAddr), .eeWrData(eeWrData), .eeDone(eeDone), .eeRdData(eeRdData));
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        nReq += int'(eeReq === 1'b1);
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end
    function automatic logic [31:0] pat(input logic [7:0] a);
        return {a + 8'h03, a + 8'h02, a + 8'h01, a} ^ 32'hA5A5_A5A5;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        priAddr <= a; priWrData <= d; priWrEn <= 1'b1;
        @(posedge mclk) priWrEn <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a);
        priAddr <= a; priRdEn <= 1'b1;
        @(negedge mclk) v = priRdData;
        @(posedge mclk) priRdEn <= 1'b0;
        @(posedge mclk);
    endtask
    // Start a transfer and poll the completion flag
    task automatic xfer(input logic f, input logic [7:0] ofs);
        int n;
        wr(PVPD_CAP_OFFSET, {f, 7'h00, ofs, 16'h0000});
        for (n = 0; n < 200; n++) begin
            rd(PVPD_CAP_OFFSET);
            if (v[31] !== f) break;
        end
        `CHK(v[31], ~f)
    endtask
    task automatic t_header();
        rd(PVPD_CAP_OFFSET); `CHK(v, 32'h0000_0003)
        rd(PVPD_DATA_OFFSET); `CHK(v, 32'h0)
        `CHK(hotSwapNextPtr, 8'h00)
        productInfoEnable <= 1'b1;
        @(posedge mclk) `CHK(hotSwapNextPtr, 8'h00)
        eepromDetected <= 1'b1;
        @(posedge mclk) `CHK(hotSwapNextPtr, 8'hE8)
    endtask
    task automatic t_read();
        xfer(1'b0, 8'h10);
        rd(PVPD_CAP_OFFSET); `CHK(v[23:0], 24'h10_0003)
        rd(PVPD_DATA_OFFSET); `CHK(v, pat(8'h10))
        secAddr <= PVPD_DATA_OFFSET; secRdEn <= 1'b1;
        @(negedge mclk) `CHK(secRdData, 32'h0)
        @(posedge mclk) secRdEn <= 1'b0;
    endtask
    task automatic t_write();
        slow <= 1'b1;
        wr(PVPD_DATA_OFFSET, 32'h1234_5678);
        xfer(1'b1, 8'hBD);
        `CHK({ee.mem[8'hC0], ee.mem[8'hBF], ee.mem[8'hBE], ee.mem[8'hBD]}, 32'h1234_5678)
        slow <= 1'b0;
        n0 = nReq;
        xfer(1'b1, 8'h3F);
        `CHK(nReq, n0)
    endtask
    task automatic t_shared();
        sharedEeprom <= 1'b1;
        xfer(1'b0, 8'h04);
        rd(PVPD_DATA_OFFSET); `CHK(v, pat(8'h44))
        n0 = nReq;
        xfer(1'b1, 8'hC0);
        `CHK(nReq, n0)
        sharedEeprom <= 1'b0;
    endtask
    task automatic t_disable();
        eepromDetected <= 1'b0;
        n0 = nReq;
        wr(PVPD_CAP_OFFSET, {8'h00, 8'h20, 16'h0000});
        repeat (10) @(posedge mclk);
        `CHK(nReq, n0)
        productInfoEnable <= 1'b0;
        wr(PVPD_DATA_OFFSET, 32'hFFFF_FFFF);
        rd(PVPD_DATA_OFFSET); `CHK(v, 32'h0)
        productInfoEnable <= 1'b1;
        eepromDetected <= 1'b1;
        rd(PVPD_DATA_OFFSET); `CHK(v, pat(8'h44))
        rd(PVPD_CAP_OFFSET); `CHK(v[23:16], 8'hC0)
    endtask
    task automatic summarize();
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_header();
        t_read();
        t_write();
        t_shared();
        t_disable();
        summarize();
    end
endmodule

// >>> tb/pvpd_ee_model.sv
// Serial EEPROM engine model: 256 bytes, one byte moved per request.
// Assumes one request at a time, all on mclk.
`timescale 1ns/1ps
module pvpd_ee_model (
    input wire logic mclk,
    input wire logic slow,
    input wire logic eeReq,
    input wire logic eeWrite,
    input wire logic [7:0] eeAddr,
    input wire logic [7:0] eeWrData,
    output logic eeDone,
    output logic [7:0] eeRdData
);
    logic [7:0] mem [256];
    logic [7:0] adr;
    int cnt = -1;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'hA5;
        eeDone = 1'b0;
        eeRdData = 8'h00;
    end
    // Read byte is valid only with eeDone; otherwise it churns
    always @(posedge mclk) begin
        eeDone <= 1'b0;
        eeRdData <= ~eeRdData;
        if (eeReq && cnt < 0) begin
            adr <= eeAddr;
            cnt <= slow ? 6 : 0;
            if (eeWrite) mem[eeAddr] <= eeWrData;
        end else if (cnt == 0) begin
            eeDone <= 1'b1;
            eeRdData <= mem[adr];
            cnt <= -1;
        end else if (cnt > 0) cnt <= cnt - 1;
    end
endmodule
